// *** caldr_top.sv ***
// Calendar date register with write unlock gating and a plain register port.
// Function
// - Bits 31 to 28 hold the year tens digit in BCD.
// - Bits 27 to 24 hold the year units digit in BCD.
// - Bits 23 to 20 hold the month tens digit, zero or one.
// - Bits 19 to 16 hold the month units digit, zero to nine.
// - Bits 15 to 12 hold the day tens digit, zero to three.
// - Bits 11 to 8 hold the day units digit, zero to nine.
// - Bits 7 to 4 are unimplemented and read as zero.
// - Bits 3 to 0 hold the weekday digit, zero to six.
// - Date writes are taken only while the write unlock bit, bit 3 of the control register, is one.
`timescale 1ns/10ps
`default_nettype none

module caldr_top
  import caldr_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic [31:0] calendar_date_value,
  output logic clock_write_unlock
);

  logic date_wr;
  logic ctrl_wr;
  logic unlock_q;
  logic [3:0] year_tens_digit;
  logic [3:0] year_units_digit;
  logic [3:0] month_tens_digit;
  logic [3:0] month_units_digit;
  logic [3:0] day_tens_digit;
  logic [3:0] day_units_digit;
  logic [3:0] weekday_digit;
  logic [31:0] date_word;
  logic [31:0] next_rdata;

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  assign ctrl_wr = reg_wr && (reg_addr == CALDR_OFS_CTRL);
  assign date_wr = reg_wr && (reg_addr == CALDR_OFS_DATE) && unlock_q;

  caldr_unlock u_unlock (
    .clk(clk),
    .srst(srst),
    .wr_en(ctrl_wr),
    .wr_bit(reg_wdata[CALDR_UNLOCK_BIT]),
    .clock_write_unlock(unlock_q)
  );

  // ----------------------------------------
  // Date digits
  // ----------------------------------------
  caldr_digit #(.MAX_VAL(CALDR_MAX_NINE)) u_year_tens (
    .clk(clk),
    .srst(srst),
    .wr_en(date_wr),
    .wr_digit(reg_wdata[CALDR_YEAR_TENS_LSB +: 4]),
    .digit(year_tens_digit)
  );

  caldr_digit #(.MAX_VAL(CALDR_MAX_NINE)) u_year_units (
    .clk(clk),
    .srst(srst),
    .wr_en(date_wr),
    .wr_digit(reg_wdata[CALDR_YEAR_UNITS_LSB +: 4]),
    .digit(year_units_digit)
  );

  caldr_digit #(.MAX_VAL(CALDR_MAX_MONTH_TENS)) u_month_tens (
    .clk(clk),
    .srst(srst),
    .wr_en(date_wr),
    .wr_digit(reg_wdata[CALDR_MONTH_TENS_LSB +: 4]),
    .digit(month_tens_digit)
  );

  caldr_digit #(.MAX_VAL(CALDR_MAX_NINE)) u_month_units (
    .clk(clk),
    .srst(srst),
    .wr_en(date_wr),
    .wr_digit(reg_wdata[CALDR_MONTH_UNITS_LSB +: 4]),
    .digit(month_units_digit)
  );

  caldr_digit #(.MAX_VAL(CALDR_MAX_DAY_TENS)) u_day_tens (
    .clk(clk),
    .srst(srst),
    .wr_en(date_wr),
    .wr_digit(reg_wdata[CALDR_DAY_TENS_LSB +: 4]),
    .digit(day_tens_digit)
  );

  caldr_digit #(.MAX_VAL(CALDR_MAX_NINE)) u_day_units (
    .clk(clk),
    .srst(srst),
    .wr_en(date_wr),
    .wr_digit(reg_wdata[CALDR_DAY_UNITS_LSB +: 4]),
    .digit(day_units_digit)
  );

  caldr_digit #(.MAX_VAL(CALDR_MAX_WEEKDAY)) u_weekday (
    .clk(clk),
    .srst(srst),
    .wr_en(date_wr),
    .wr_digit(reg_wdata[CALDR_WEEKDAY_LSB +: 4]),
    .digit(weekday_digit)
  );

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  assign date_word = {year_tens_digit, year_units_digit, month_tens_digit, month_units_digit,
                      day_tens_digit, day_units_digit, 4'h0, weekday_digit};

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (reg_rd) begin
      if (reg_addr == CALDR_OFS_DATE) begin
        next_rdata = date_word;
      end else if (reg_addr == CALDR_OFS_CTRL) begin
        next_rdata[CALDR_UNLOCK_BIT] = unlock_q;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // ----------------------------------------
  // Registered state outputs
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      calendar_date_value <= 32'h0000_0000;
      clock_write_unlock <= CALDR_UNLOCK_RST;
    end else begin
      calendar_date_value <= date_word;
      clock_write_unlock <= unlock_q;
    end
  end

endmodule

`default_nettype wire

// *** caldr_pkg.sv ***
// Package with constants for the calendar date register block.
`default_nettype none
package caldr_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [3:0] CALDR_OFS_DATE = 4'h0;
  localparam logic [3:0] CALDR_OFS_CTRL = 4'h4;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CALDR_YEAR_TENS_LSB = 28;
  localparam int CALDR_YEAR_UNITS_LSB = 24;
  localparam int CALDR_MONTH_TENS_LSB = 20;
  localparam int CALDR_MONTH_UNITS_LSB = 16;
  localparam int CALDR_DAY_TENS_LSB = 12;
  localparam int CALDR_DAY_UNITS_LSB = 8;
  localparam int CALDR_WEEKDAY_LSB = 0;
  localparam int CALDR_UNLOCK_BIT = 3;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [3:0] CALDR_DIGIT_RST = 4'h0;
  localparam logic CALDR_UNLOCK_RST = 1'b0;

  // ----------------------------------------
  // Digit limits
  // ----------------------------------------
  localparam logic [3:0] CALDR_MAX_NINE = 4'h9;
  localparam logic [3:0] CALDR_MAX_MONTH_TENS = 4'h1;
  localparam logic [3:0] CALDR_MAX_DAY_TENS = 4'h3;
  localparam logic [3:0] CALDR_MAX_WEEKDAY = 4'h6;

endpackage

`default_nettype wire

// *** caldr_digit.sv ***
// One gated BCD digit holding register with a range limit.
`timescale 1ns/10ps
`default_nettype none

module caldr_digit
  import caldr_pkg::*;
#(
  parameter logic [3:0] MAX_VAL = 4'h9
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic wr_en,
  input wire logic [3:0] wr_digit,
  output logic [3:0] digit
);

  if (MAX_VAL > CALDR_MAX_NINE) begin : g_bad_limit
    $error("Digit limit exceeds nine.");
  end

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      digit <= CALDR_DIGIT_RST;
    end else if (wr_en && (wr_digit <= MAX_VAL)) begin
      digit <= wr_digit;
    end
  end

endmodule

`default_nettype wire

// *** caldr_unlock.sv ***
// Clock control register holding the write unlock bit.
`timescale 1ns/10ps
`default_nettype none

module caldr_unlock
  import caldr_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic wr_en,
  input wire logic wr_bit,
  output logic clock_write_unlock
);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      clock_write_unlock <= CALDR_UNLOCK_RST;
    end else if (wr_en) begin
      clock_write_unlock <= wr_bit;
    end
  end

endmodule

`default_nettype wire

// *** caldr_chk.sv ***
// Assertion checker on the calendar date register ports.
`timescale 1ns/10ps
`default_nettype none
module caldr_chk (
  input wire logic clk,
  input wire logic srst,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [31:0] calendar_date_value,
  input wire logic clock_write_unlock
);
  wire [31:0] v = calendar_date_value;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // A date write made while the unlock bit is settled low.
  sequence s_locked_wr;
    reg_wr && reg_addr == 4'h0 && !clock_write_unlock && !$past(reg_wr);
  endsequence
  // A date write made while the unlock bit is settled high, with every digit in range.
  sequence s_open_wr;
    reg_wr && reg_addr == 4'h0 && clock_write_unlock && !$past(reg_wr) &&
      reg_wdata[31:28] <= 4'h9 && reg_wdata[27:24] <= 4'h9 && reg_wdata[23:20] <= 4'h1 &&
      reg_wdata[19:16] <= 4'h9 && reg_wdata[15:12] <= 4'h3 && reg_wdata[11:8] <= 4'h9 &&
      reg_wdata[3:0] <= 4'h6;
  endsequence
  a_year_tens: assert property (v[31:28] <= 4'h9) else $error("year tens bad");
  a_year_units: assert property (v[27:24] <= 4'h9) else $error("year units bad");
  a_month_tens: assert property (v[23:20] <= 4'h1) else $error("month tens bad");
  a_month_units: assert property (v[19:16] <= 4'h9) else $error("month units bad");
  a_day_tens: assert property (v[15:12] <= 4'h3) else $error("day tens bad");
  a_day_units: assert property (v[11:8] <= 4'h9) else $error("day units bad");
  a_pad_zero: assert property ($past(reg_rd) |-> reg_rdata[7:4] == 4'h0 && v[7:4] == 4'h0) else $error("pad");
  a_weekday_max: assert property (v[3:0] <= 4'h6) else $error("weekday bad");
  a_locked_hold: assert property (s_locked_wr |=> ##1 $stable(v)) else $error("locked write taken");
  a_open_write: assert property (s_open_wr |=> ##1 v == ($past(reg_wdata, 2) & 32'hFFFF_FF0F))
    else $error("unlocked write lost");
  a_idle_rdata: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000) else $error("rdata not 0");
endmodule
`default_nettype wire

// *** caldr_tb.sv ***
// Self-checking testbench for the calendar date register.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import caldr_pkg::*;
  logic clk, srst, reg_wr, reg_rd, rd_d, ul, cwu;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, cdv, exp_d, d;
  logic [31:0] q[$];
  int err_total, comparisons, cyc, seed;
  caldr_top dut (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .calendar_date_value(cdv), .clock_write_unlock(cwu));
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  function automatic logic [31:0] upd(logic [31:0] o, logic [31:0] w);
    logic [3:0] lim[8] = '{CALDR_MAX_WEEKDAY, 4'h0, CALDR_MAX_NINE, CALDR_MAX_DAY_TENS, CALDR_MAX_NINE,
      CALDR_MAX_MONTH_TENS, CALDR_MAX_NINE, CALDR_MAX_NINE};
    for (int i = 0; i < 8; i++) if (w[i*4+:4] <= lim[i]) o[i*4+:4] = w[i*4+:4];
    return o;
  endfunction
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(logic [3:0] a, logic [31:0] w);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= w;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    if (a == 4'h4) ul = w[3];
    if (a == 4'h0 && ul) exp_d = upd(exp_d, w);
  endtask
  task automatic rd(logic [3:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    q.push_back(a == 4'h0 ? exp_d : a == 4'h4 ? {28'h000_0000, ul, 3'h0} : 32'h0000_0000);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask
  // Monitor: compares each read answer with the oldest note.
  always @(posedge clk) begin
    rd_d <= reg_rd;
    cyc <= cyc + 1;
    if (rd_d) chk("reg_rdata", q.pop_front(), reg_rdata);
    if (cyc == 4000) begin
      err_total++;
      final_report();
    end
  end
  initial begin
    seed = 38;
    srst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0000_0000;
    ul = 1'b0;
    exp_d = 32'h0000_0000;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rd(4'h0);
    rd(4'h4);
    wr(4'h0, 32'h9919_3916);
    rd(4'h0);
    $display("test reset and lock done");
    wr(4'h4, 32'h0000_0008);
    rd(4'h4);
    wr(4'h0, 32'h9919_39F6);
    rd(4'h0);
    wr(4'h0, 32'hAA2A_4A07);
    rd(4'h0);
    wr(4'h4, 32'hFFFF_FFF7);
    rd(4'h4);
    wr(4'h0, 32'h1203_1105);
    rd(4'h0);
    $display("test limits done");
    for (int i = 0; i < 60; i++) begin
      d = $random(seed);
      if (i % 6 == 0) begin
        wr(4'h4, $random(seed));
        rd(4'h4);
      end
      wr(4'h0, i[0] ? d : d & 32'h7717_3716);
      rd(4'h0);
      wr(4'h8 | i[2:0], ~d);
      rd(4'h8 | i[2:0]);
    end
    repeat (3) @(posedge clk);
    chk("calendar_date_value", exp_d, cdv);
    chk("clock_write_unlock", {31'h0000_0000, ul}, {31'h0000_0000, cwu});
    $display("test random traffic done");
    final_report();
  end
endmodule
bind caldr_top caldr_chk u_chk (.clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .calendar_date_value, .clock_write_unlock);
`default_nettype wire
